// *** common/waveform_pkg.sv ***
// shared constants, state ids and the state table for the waveform engine
// assumes both ends and the bench import it; no process lives here
package waveform_pkg;

    // ==========================================================
    // widths
    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 8;
    localparam int LEN_W   = 8;
    localparam int STATE_W = 3;
    localparam int REP_W   = 4;
    localparam int ACT_W   = 4;
    localparam int LUT_W   = 16;

    // ==========================================================
    // trigger inputs: exactly four feed every equation
    localparam int TRIG_W     = 4;
    localparam int TRIG_RD    = 0;
    localparam int TRIG_WR    = 1;
    localparam int TRIG_EOP   = 2;
    localparam int TRIG_ANYWR = 3;

    // ==========================================================
    // mirror selection
    localparam int MIRROR_MAX = 8;
    localparam int GLOBAL_MAX = 3;
    localparam int GLOBAL_CNT = 2;
    localparam int GLOBAL_POS [GLOBAL_MAX] = '{TRIG_WR, TRIG_EOP, TRIG_RD};

    // ==========================================================
    // action bit positions
    localparam int ACT_ADDR  = 0;
    localparam int ACT_DRIVE = 1;
    localparam int ACT_IN    = 2;
    localparam int ACT_CLOSE = 3;
    localparam logic [ACT_W-1:0] ACTS_NONE  = 4'h0;
    localparam logic [ACT_W-1:0] ACTS_READ  = 4'h3;
    localparam logic [ACT_W-1:0] ACTS_WRITE = 4'h4;
    localparam logic [ACT_W-1:0] ACTS_SHORT = 4'hc;
    localparam logic [ACT_W-1:0] ACTS_EMPTY = 4'h8;
    localparam logic [REP_W-1:0] REP_NONE   = 4'h0;

    // ==========================================================
    // equation truth tables, indexed by the four-bit trigger vector
    localparam logic [LUT_W-1:0] EQ_NONE       = 16'h0000;
    localparam logic [LUT_W-1:0] EQ_ALWAYS     = 16'hffff;
    localparam logic [LUT_W-1:0] EQ_RD_XOR_ANY = 16'h55aa;
    localparam logic [LUT_W-1:0] EQ_NOT_RD     = 16'h5555;
    localparam logic [LUT_W-1:0] EQ_NOT_WR     = 16'h3333;
    localparam logic [LUT_W-1:0] EQ_WR_EOP     = 16'hc0c0;
    localparam logic [LUT_W-1:0] EQ_ANY        = 16'hfefe;
    localparam logic [LUT_W-1:0] EQ_QUIET      = 16'h0101;

    // ==========================================================
    // state ids; mirror copies of the dispatch sit at read_state + {eop, wr}
    typedef enum logic [STATE_W-1:0] {
        idle_state         = 3'b000,
        split_state        = 3'b001,
        read_state         = 3'b100,
        write_state        = 3'b101,
        empty_packet_state = 3'b110,
        short_packet_state = 3'b111
    } state_id_type;

    typedef enum logic [1:0] {
        cmd_read  = 2'b00,
        cmd_write = 2'b01,
        cmd_empty = 2'b10,
        cmd_short = 2'b11
    } cmd_kind_type;

    // at most two outgoing transitions per row, each optionally mirrored
    typedef struct packed {
        logic [ACT_W-1:0] act;
        logic [REP_W-1:0] rep;
        logic [LUT_W-1:0] lut0;
        logic             mir0;
        state_id_type     dst0;
        logic [LUT_W-1:0] lut1;
        logic             mir1;
        state_id_type     dst1;
    } row_type;

    function automatic row_type table_row(input logic split, input state_id_type s);
        row_type r;
        r = '{ACTS_NONE, REP_NONE, EQ_NONE, 1'b0, idle_state, EQ_NONE, 1'b0, idle_state};
        unique case (s)
            idle_state: begin
                if (split) begin
                    r = '{ACTS_NONE, REP_NONE, EQ_ANY, 1'b0, split_state, EQ_NONE, 1'b0, idle_state};
                end else begin
                    r = '{ACTS_NONE, REP_NONE, EQ_RD_XOR_ANY, 1'b1, read_state, EQ_NONE, 1'b0, idle_state};
                end
            end
            split_state: begin
                r = '{ACTS_NONE, REP_NONE, EQ_RD_XOR_ANY, 1'b1, read_state, EQ_QUIET, 1'b0, idle_state};
            end
            read_state: begin
                r = '{ACTS_READ, REP_NONE, EQ_NOT_RD, 1'b0, idle_state, EQ_NONE, 1'b0, idle_state};
            end
            write_state: begin
                r = '{ACTS_WRITE, REP_NONE, EQ_WR_EOP, 1'b0, short_packet_state, EQ_NOT_WR, 1'b0, idle_state};
            end
            empty_packet_state: begin
                r = '{ACTS_EMPTY, REP_NONE, EQ_ALWAYS, 1'b0, idle_state, EQ_NONE, 1'b0, idle_state};
            end
            short_packet_state: begin
                r = '{ACTS_SHORT, REP_NONE, EQ_ALWAYS, 1'b0, idle_state, EQ_NONE, 1'b0, idle_state};
            end
            default: begin
                r = '{ACTS_NONE, REP_NONE, EQ_ALWAYS, 1'b0, idle_state, EQ_NONE, 1'b0, idle_state};
            end
        endcase
        return r;
    endfunction

endpackage

// *** common/pport_if.sv ***
// parallel port between the bus master and the waveform engine
// assumes the bench resolves the shared data wire from the two enables
`timescale 1ns/100ps
interface pport_if
    import waveform_pkg::*;
#(
    parameter int DW = DATA_W,
    parameter int AW = ADDR_W
) ();
    logic          rd;
    logic          wr;
    logic          eop;
    logic [AW-1:0] addr;
    logic [DW-1:0] hdata;
    logic          hdata_oe;
    logic [DW-1:0] ddata;
    logic          ddata_oe;

    modport dev (
        input  rd,
        input  wr,
        input  eop,
        input  addr,
        input  hdata,
        input  hdata_oe,
        output ddata,
        output ddata_oe
    );

    modport host (
        output rd,
        output wr,
        output eop,
        output addr,
        output hdata,
        output hdata_oe,
        input  ddata,
        input  ddata_oe
    );
endinterface

// *** hdl/waveform_engine.sv ***
// table-driven waveform engine: the device end of the parallel port
// assumes one clock, inputs synchronous to it, buffer on the user side
// assumes the far end holds dispatch inputs one cycle longer with SPLIT
//
// What this block does
// - each state has at most two exits
// - each equation reads at most four triggers
// - up to eight mirror copies; two of three globals used, so four reachable
// - mirrored exit picks copy from global triggers
// - mirror pairs share one equation sans globals
// - mirrored destinations never carry conflicting actions
// - idle, read alone: read state, drive data
// - idle, write alone: write state, capture data
// - idle, write with end: capture and packet_close_action
// - idle, end alone: packet_close_action empty packet
// - dispatch is four mirrors on write/end
// - dummy state adds one cycle, inputs held
// - repeat count holds state before evaluating exits
// - runs synchronously on the internal clock
// - data-in state captures a word every cycle
`timescale 1ns/100ps
module waveform_engine
    import waveform_pkg::*;
#(
    parameter int   DW    = DATA_W,
    parameter int   AW    = ADDR_W,
    parameter logic SPLIT = 1'b0
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    pport_if.dev               port,
    input  wire logic [DW-1:0] src_data,
    output logic               src_take_q,
    output logic [AW-1:0]      rd_addr_q,
    output logic [DW-1:0]      buf_data_q,
    output logic               buf_valid_q,
    output logic               buf_packet_close_action_q,
    output state_id_type       state_q
);

    // ==========================================================
    // triggers and mirror index
    logic [TRIG_W-1:0]  trig;
    logic [STATE_W-1:0] mirror_idx;

    // write-or-end lets every dispatch copy share one equation
    assign trig[TRIG_RD]    = port.rd;
    assign trig[TRIG_WR]    = port.wr;
    assign trig[TRIG_EOP]   = port.eop;
    assign trig[TRIG_ANYWR] = port.wr | port.eop;

    // ==========================================================
    // mirror index from the global triggers
    genvar g;
    generate
        for (g = 0; g < GLOBAL_MAX; g++) begin : gen_global
            if (g < GLOBAL_CNT) begin : gen_used
                assign mirror_idx[g] = trig[GLOBAL_POS[g]];
            end else begin : gen_unused
                assign mirror_idx[g] = 1'b0;
            end
        end
    endgenerate

    // ==========================================================
    // state register and repeat counter
    row_type          row;
    row_type          next_row;
    logic             fire0;
    logic             fire1;
    logic             hold;
    state_id_type     pick0;
    state_id_type     pick1;
    state_id_type     cand0 [MIRROR_MAX];
    state_id_type     cand1 [MIRROR_MAX];
    state_id_type     state_d;
    logic [REP_W-1:0] cnt_q;
    logic [REP_W-1:0] cnt_d;

    function automatic state_id_type dest(input logic mir, input state_id_type dst,
                                          input logic [STATE_W-1:0] idx);
        // copies of one mirrored target are laid out consecutively
        return mir ? state_id_type'(STATE_W'(dst) + idx) : dst;
    endfunction

    // ==========================================================
    // present row and its exits
    assign row   = table_row(SPLIT, state_q);
    assign fire0 = row.lut0[trig];
    assign fire1 = row.lut1[trig];
    assign hold  = (cnt_q != REP_NONE);

    // ==========================================================
    // mirror copies: each offers a target, the globals pick one
    generate
        for (g = 0; g < MIRROR_MAX; g++) begin : gen_copy
            // copies past the used globals are never picked
            assign cand0[g] = dest(row.mir0, row.dst0, STATE_W'(g));
            assign cand1[g] = dest(row.mir1, row.dst1, STATE_W'(g));
        end
    endgenerate

    // globals count as they stand now, so no stale copy is taken
    assign pick0 = cand0[mirror_idx];
    assign pick1 = cand1[mirror_idx];

    // ==========================================================
    // next state and repeat count
    // a pending repeat count blocks both exits
    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        if (hold) begin
            cnt_d = cnt_q - 1'b1;
        end else if (fire0) begin
            state_d = pick0;
        end else if (fire1) begin
            state_d = pick1;
        end
        next_row = table_row(SPLIT, state_d);
        if (state_d != state_q) begin
            cnt_d = next_row.rep;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= idle_state;
            cnt_q   <= REP_NONE;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // ==========================================================
    // actions: drive is set up for the coming state, capture acts on the present one
    logic          drive_q;
    logic          drive_d;
    logic [DW-1:0] ddata_q;
    logic [DW-1:0] ddata_d;
    logic          src_take_d;
    logic [AW-1:0] rd_addr_d;
    logic [DW-1:0] buf_data_d;
    logic          buf_valid_d;
    logic          buf_packet_close_action_d;
    logic          act_addr;
    logic          act_in;
    logic          act_close;

    // ==========================================================
    // action decode of the present row
    assign act_addr  = row.act[ACT_ADDR];
    assign act_in    = row.act[ACT_IN];
    assign act_close = row.act[ACT_CLOSE];

    // action sets per state are fixed in the table so copies never clash
    always_comb begin
        drive_d      = next_row.act[ACT_DRIVE];
        ddata_d      = ddata_q;
        if (drive_d) begin
            ddata_d = src_data;
        end
        src_take_d   = drive_d;
        rd_addr_d    = rd_addr_q;
        if (act_addr) begin
            rd_addr_d = port.addr;
        end
        buf_valid_d  = act_in;
        buf_data_d   = buf_data_q;
        if (act_in) begin
            buf_data_d = port.hdata;
        end
        buf_packet_close_action_d = act_close;
    end

    // ==========================================================
    // registered outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_q      <= 1'b0;
            ddata_q      <= '0;
            src_take_q   <= 1'b0;
            rd_addr_q    <= '0;
            buf_data_q   <= '0;
            buf_valid_q  <= 1'b0;
            buf_packet_close_action_q <= 1'b0;
        end else begin
            drive_q      <= drive_d;
            ddata_q      <= ddata_d;
            src_take_q   <= src_take_d;
            rd_addr_q    <= rd_addr_d;
            buf_data_q   <= buf_data_d;
            buf_valid_q  <= buf_valid_d;
            buf_packet_close_action_q <= buf_packet_close_action_d;
        end
    end

    // ==========================================================
    // port drive: both enables come from flops, so no glitch reaches the bus
    assign port.ddata    = ddata_q;
    assign port.ddata_oe = drive_q;

endmodule

// *** hdl/bus_master.sv ***
// external bus master: turns user commands into pin sequences on the port
// assumes the engine at the far end uses the same SPLIT setting
`timescale 1ns/100ps
module bus_master
    import waveform_pkg::*;
#(
    parameter int   DW    = DATA_W,
    parameter int   AW    = ADDR_W,
    parameter int   LW    = LEN_W,
    parameter logic SPLIT = 1'b0
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    pport_if.host              port,
    input  wire logic          cmd_valid,
    input  wire cmd_kind_type  cmd_kind,
    input  wire logic [LW-1:0] cmd_len,
    input  wire logic [AW-1:0] cmd_addr,
    input  wire logic [DW-1:0] wdata,
    output logic               cmd_ready_q,
    output logic               wdata_take_q,
    output logic [DW-1:0]      rdata_q,
    output logic               rvalid_q
);

    typedef enum logic [2:0] {
        h_idle    = 3'b000,
        h_stretch = 3'b001,
        h_hold    = 3'b010,
        h_burst   = 3'b011,
        h_read    = 3'b100,
        h_turn    = 3'b101
    } host_state_type;

    // ==========================================================
    // next-state logic
    host_state_type state_q;
    host_state_type state_d;
    logic [LW:0]    rem_q;
    logic [LW:0]    rem_d;
    logic           rd_q;
    logic           rd_d;
    logic           wr_q;
    logic           wr_d;
    logic           eop_q;
    logic           eop_d;
    logic [AW-1:0]  addr_q;
    logic [AW-1:0]  addr_d;
    logic [DW-1:0]  hdata_q;
    logic [DW-1:0]  hdata_d;
    logic           hoe_q;
    logic           hoe_d;
    logic           ready_d;
    logic           take_d;
    logic [DW-1:0]  rdata_d;
    logic           rvalid_d;
    logic [LW:0]    len_eff;
    logic [LW:0]    split_ext;

    always_comb begin
        // a zero length is taken as one word
        len_eff   = (cmd_len == '0) ? (LW+1)'(1) : {1'b0, cmd_len};
        split_ext = SPLIT ? (LW+1)'(1) : '0;
        state_d   = state_q;
        rem_d     = rem_q;
        rd_d      = rd_q;
        wr_d      = wr_q;
        eop_d     = eop_q;
        addr_d    = addr_q;
        hdata_d   = hdata_q;
        hoe_d     = hoe_q;
        ready_d   = cmd_ready_q;
        take_d    = 1'b0;
        rdata_d   = rdata_q;
        rvalid_d  = 1'b0;
        unique case (state_q)
            h_idle: begin
                if (cmd_valid) begin
                    // full trigger sets, so the dispatch copy is unambiguous
                    rd_d    = (cmd_kind == cmd_read);
                    wr_d    = (cmd_kind == cmd_write) || (cmd_kind == cmd_short);
                    eop_d   = (cmd_kind == cmd_empty) || (cmd_kind == cmd_short);
                    hoe_d   = wr_d;
                    addr_d  = cmd_addr;
                    hdata_d = wdata;
                    ready_d = 1'b0;
                    if (rd_d) begin
                        rem_d   = len_eff + split_ext - 1'b1;
                        state_d = h_read;
                    end else begin
                        rem_d   = len_eff - 1'b1;
                        state_d = SPLIT ? h_stretch : h_hold;
                    end
                end
            end
            h_stretch: begin
                state_d = h_hold;
            end
            h_hold: begin
                // first word stays one more cycle while the engine enters its state
                wr_d    = wr_q && (rem_q != '0);
                eop_d   = 1'b0;
                take_d  = wr_q && (rem_q != '0);
                state_d = h_burst;
            end
            h_burst: begin
                if (rem_q != '0) begin
                    hdata_d = wdata;
                    rem_d   = rem_q - 1'b1;
                    wr_d    = (rem_q != (LW+1)'(1));
                    take_d  = (rem_q != (LW+1)'(1));
                end else begin
                    wr_d    = 1'b0;
                    hoe_d   = 1'b0;
                    state_d = h_turn;
                end
            end
            h_read: begin
                rd_d     = (rem_q != '0);
                if (rem_q != '0) begin
                    rem_d = rem_q - 1'b1;
                end
                rvalid_d = port.ddata_oe;
                if (port.ddata_oe) begin
                    rdata_d = port.ddata;
                end
                if (!rd_q && !port.ddata_oe) begin
                    ready_d = 1'b1;
                    state_d = h_idle;
                end
            end
            h_turn: begin
                ready_d = 1'b1;
                state_d = h_idle;
            end
            default: begin
                rd_d    = 1'b0;
                wr_d    = 1'b0;
                eop_d   = 1'b0;
                hoe_d   = 1'b0;
                ready_d = 1'b1;
                state_d = h_idle;
            end
        endcase
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q      <= h_idle;
            rem_q        <= '0;
            rd_q         <= 1'b0;
            wr_q         <= 1'b0;
            eop_q        <= 1'b0;
            addr_q       <= '0;
            hdata_q      <= '0;
            hoe_q        <= 1'b0;
            cmd_ready_q  <= 1'b1;
            wdata_take_q <= 1'b0;
            rdata_q      <= '0;
            rvalid_q     <= 1'b0;
        end else begin
            state_q      <= state_d;
            rem_q        <= rem_d;
            rd_q         <= rd_d;
            wr_q         <= wr_d;
            eop_q        <= eop_d;
            addr_q       <= addr_d;
            hdata_q      <= hdata_d;
            hoe_q        <= hoe_d;
            cmd_ready_q  <= ready_d;
            wdata_take_q <= take_d;
            rdata_q      <= rdata_d;
            rvalid_q     <= rvalid_d;
        end
    end

    assign port.rd       = rd_q;
    assign port.wr       = wr_q;
    assign port.eop      = eop_q;
    assign port.addr     = addr_q;
    assign port.hdata    = hdata_q;
    assign port.hdata_oe = hoe_q;

endmodule

// *** bench/pport_properties.sv ***
// concurrent checks on the parallel port between bus master and engine
// assumes instantiation beside the port interface, signals passed by name
`timescale 1ns/100ps
module pport_properties
    import waveform_pkg::*;
#(
    parameter int DW = DATA_W,
    parameter int AW = ADDR_W
) (
    input wire logic          clk,
    input wire logic          rst_n,
    input wire logic          rd,
    input wire logic          wr,
    input wire logic          eop,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] hdata,
    input wire logic          hdata_oe,
    input wire logic [DW-1:0] ddata,
    input wire logic          ddata_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // read path
    read_drive_a:
        assert property (rd && !wr && !eop && !ddata_oe |=> ddata_oe)
        else $error("engine did not drive after a lone read request");
    read_hold_a:
        assert property (ddata_oe && rd |=> ddata_oe)
        else $error("engine left read state while read still high");
    read_end_a:
        assert property ($fell(rd) |-> ddata_oe ##1 !ddata_oe)
        else $error("drive window does not close one cycle after read drops");
    addr_hold_a:
        assert property (rd && $past(rd) |-> $stable(addr))
        else $error("address moved during a read request");
    drive_cause_a:
        assert property ($rose(ddata_oe) |-> $past(rd) && !$past(wr) && !$past(eop))
        else $error("engine drove without a lone read request");
    bus_excl_a:
        assert property (!(hdata_oe && ddata_oe))
        else $error("both ends drive the data bus");

    // ==========================================================
    // write, short and empty packet paths
    write_data_a:
        assert property ($rose(wr) |-> hdata_oe)
        else $error("write raised without data on the bus");
    write_release_a:
        assert property ($fell(wr) |-> hdata_oe ##1 !hdata_oe)
        else $error("last write word not held exactly one cycle");
    short_pulse_a:
        assert property (wr && eop |=> !wr && !eop)
        else $error("short packet request longer than one cycle");
    empty_pulse_a:
        assert property (eop && !wr |=> !eop [*2])
        else $error("empty packet request not a single pulse");
endmodule

// *** bench/programmable_waveform_fsm_tb.sv ***
// self-checking bench: bus master and waveform engine face each other
// assumes SPLIT off on both ends; bench feeds write and source words
`timescale 1ns/100ps
module programmable_waveform_fsm_tb
    import waveform_pkg::*;
;
    logic              clk;
    logic              rst_n;
    logic              cmd_valid;
    cmd_kind_type      cmd_kind;
    logic [LEN_W-1:0]  cmd_len;
    logic [ADDR_W-1:0] cmd_addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] src_data;
    logic              cmd_ready_q;
    logic              wdata_take_q;
    logic [DATA_W-1:0] rdata_q;
    logic              rvalid_q;
    logic              src_take_q;
    logic [ADDR_W-1:0] rd_addr_q;
    logic [DATA_W-1:0] buf_data_q;
    logic              buf_valid_q;
    logic              buf_packet_close_action_q;
    state_id_type      state_q;
    int                err_total;
    int                comparisons;
    int                wr_idx;
    int                src_idx;
    int                commits;
    logic [7:0]        seen;
    logic [DATA_W-1:0] got_buf[$];
    logic [DATA_W-1:0] got_rd[$];

    pport_if #(.DW(DATA_W), .AW(ADDR_W)) port_if ();

    bus_master #(.SPLIT(1'b0)) u_bus_master (
        .clk(clk), .rst_n(rst_n), .port(port_if), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
        .cmd_len(cmd_len), .cmd_addr(cmd_addr), .wdata(wdata), .cmd_ready_q(cmd_ready_q),
        .wdata_take_q(wdata_take_q), .rdata_q(rdata_q), .rvalid_q(rvalid_q)
    );

    waveform_engine #(.SPLIT(1'b0)) u_waveform_engine (
        .clk(clk), .rst_n(rst_n), .port(port_if), .src_data(src_data), .src_take_q(src_take_q),
        .rd_addr_q(rd_addr_q), .buf_data_q(buf_data_q), .buf_valid_q(buf_valid_q),
        .buf_packet_close_action_q(buf_packet_close_action_q), .state_q(state_q)
    );

    pport_properties #(.DW(DATA_W), .AW(ADDR_W)) u_pport_properties (
        .clk(clk), .rst_n(rst_n), .rd(port_if.rd), .wr(port_if.wr), .eop(port_if.eop),
        .addr(port_if.addr), .hdata(port_if.hdata), .hdata_oe(port_if.hdata_oe),
        .ddata(port_if.ddata), .ddata_oe(port_if.ddata_oe)
    );

    // ==========================================================
    // clock and word sources
    always #2 clk = ~clk;

    function automatic logic [DATA_W-1:0] wword(input int i);
        return 32'h1234_0000 + 32'(i);
    endfunction

    function automatic logic [DATA_W-1:0] sword(input int i);
        return 32'hc0de_0000 + 32'(i);
    endfunction

    // next word must be ready in the cycle the take pulse shows
    always @(negedge clk) begin
        if (src_take_q === 1'b1) src_idx++;
        if (wdata_take_q === 1'b1) wr_idx++;
        src_data = sword(src_idx);
        wdata = wword(wr_idx);
        if (buf_valid_q === 1'b1) got_buf.push_back(buf_data_q);
        if (rvalid_q === 1'b1) got_rd.push_back(rdata_q);
        if (buf_packet_close_action_q === 1'b1) commits++;
        seen[state_q] = 1'b1;
    end

    // ==========================================================
    // checking and access tasks
    task automatic wrap_up();
        $display("mismatches %0d, comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        while (cmd_ready_q !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 1000) begin
            err_total++;
            $display("unexpected at %0t: ready %h expected %h", $time, cmd_ready_q, 1'b1);
        end
    endtask

    task automatic run_cmd(input cmd_kind_type kind, input logic [7:0] len, input logic [7:0] addr,
                           input state_id_type st);
        int nw;
        int wb;
        int rb;
        logic rdk;
        rdk = (kind == cmd_read);
        nw = (rdk || kind == cmd_write) ? ((len == 8'h00) ? 1 : int'(len)) : (kind == cmd_short ? 1 : 0);
        wait_ready();
        wb = wr_idx;
        rb = src_idx;
        got_buf.delete();
        got_rd.delete();
        commits = 0;
        seen = 8'h00;
        cmd_valid = 1'b1;
        cmd_kind = kind;
        cmd_len = len;
        cmd_addr = addr;
        @(negedge clk);
        cmd_valid = 1'b0;
        wait_ready();
        repeat (4) @(negedge clk);
        check(32'(seen[st]), 32'h0000_0001);
        check(32'(state_q), 32'(idle_state));
        check(32'(commits), (kind == cmd_short || kind == cmd_empty) ? 32'h1 : 32'h0);
        check(32'(got_rd.size()), rdk ? 32'(nw) : 32'h0);
        check(32'(got_buf.size()), rdk ? 32'h0 : 32'(nw));
        for (int i = 0; i < got_rd.size() && i < nw; i++) begin
            check(got_rd[i], sword(rb + i));
        end
        for (int i = 0; i < got_buf.size() && i < nw; i++) begin
            check(got_buf[i], wword(wb + i));
        end
        if (rdk) check(32'(rd_addr_q), 32'(addr));
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_kind = cmd_read;
        cmd_len = 8'h00;
        cmd_addr = 8'h00;
        wdata = wword(0);
        src_data = sword(0);
        err_total = 0;
        comparisons = 0;
        wr_idx = 0;
        src_idx = 0;
        commits = 0;
        seen = 8'h00;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        check(32'(state_q), 32'(idle_state));
        run_cmd(cmd_read, 8'h02, 8'h5a, read_state);
        run_cmd(cmd_write, 8'h03, 8'h00, write_state);
        run_cmd(cmd_short, 8'h00, 8'h00, short_packet_state);
        run_cmd(cmd_empty, 8'h00, 8'h00, empty_packet_state);
        run_cmd(cmd_read, 8'h00, 8'ha5, read_state);
        run_cmd(cmd_write, 8'hff, 8'h00, write_state);
        run_cmd(cmd_empty, 8'h00, 8'h00, empty_packet_state);
        run_cmd(cmd_short, 8'h00, 8'h00, short_packet_state);
        repeat (10) @(negedge clk);
        check(32'(state_q), 32'(idle_state));
        check(32'(got_buf.size()), 32'h0000_0001);
        wrap_up();
    end

    // the full sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("unexpected at %0t: watchdog %h expected %h", $time, 1'b1, 1'b0);
        wrap_up();
    end
endmodule
